// File: hw/sarc_pkg.sv
package sarc_pkg;
    localparam int SARC_W = 16;
    localparam int SARC_SYS_NS = 40;
    localparam int SARC_CONV_NS = 1000;
    localparam int SARC_CONV_CYC =
        (SARC_CONV_NS + SARC_SYS_NS - 1) / SARC_SYS_NS;
    localparam int SARC_TMR_W = 6;
    localparam logic [SARC_TMR_W-1:0] SARC_CONV_LAST =
        SARC_TMR_W'(SARC_CONV_CYC - 1);
    localparam logic [SARC_TMR_W-1:0] SARC_TMR_RST = 6'h00;
    localparam int SARC_FIFO_DEPTH = 4;
    localparam logic [SARC_W-1:0] SARC_SIGN_BIT = 16'h8000;
    localparam logic [SARC_W-1:0] SARC_WORD_RST = 16'h0000;

    typedef enum logic [1:0] {
        ST_NAP,
        ST_CONV,
        ST_XFER
    } sarc_state_e;
endpackage

// File: hw/sarc_adc_ctrl.sv
`timescale 1ns/100ps
// Operation
// - convert strobe rising edge starts a conversion
// - chain select low: shared pin gates output
// - chain select high: shared pin is serial in
// - busy high from start until conversion done
// - serial out advances per rising serial clock edge, MSB first
// - 16-bit code loaded into shift path at end
// - output code is two's complement
// - successive approximation, one bit per step
// - conversion timed by internal clock only
// - nap after each conversion until next strobe
// - acquire until strobe edge, then convert
// - result readable right after its own conversion
// - read enable low drives output, high releases

module sarc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // depth must be a power of two: pointers wrap freely
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } sarc_fifo_s;

    sarc_fifo_s state_q;
    sarc_fifo_s state_d;
    logic push;
    logic pop;

    always_comb begin
        in_ready = state_q.cnt != (AW+1)'(DEPTH);
        out_valid = state_q.cnt != '0;
        out_data = state_q.mem[state_q.rd];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        state_d = state_q;
        if (push) begin
            state_d.mem[state_q.wr] = in_data;
            state_d.wr = state_q.wr + 1'b1;
        end
        if (pop) begin
            state_d.rd = state_q.rd + 1'b1;
        end
        state_d.cnt = state_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule

// two flops per bit before the sys_clk logic reads a pin (chain data goes raw to the shifter); the bits of a
// wide level may land one cycle apart, which is harmless here
// because the level is held long before the strobe edge
module sarc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] synced
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sarc_sync_s;

    sarc_sync_s state_q;
    sarc_sync_s state_d;

    always_comb begin
        state_d.s1 = pin;
        // only the second flop is read
        state_d.s2 = state_q.s1;
        synced = state_q.s2;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule

// runs on the host's serial clock; cleared while busy so every
// frame starts from the freshly held word
module sarc_shift import sarc_pkg::*; (
    input wire logic serial_clk,
    input wire logic link_clear,
    input wire logic [SARC_W-1:0] hold_word,
    input wire logic chain_in,
    output logic serial_bit
);
    typedef struct packed {
        logic [SARC_W-1:0] sh;
        logic started;
    } sarc_shift_s;

    sarc_shift_s state_q;
    sarc_shift_s state_d;

    always_comb begin
        state_d = state_q;
        state_d.started = 1'b1;
        // upstream bits fall in behind our own word
        if (!state_q.started) begin
            state_d.sh = {hold_word[SARC_W-2:0], chain_in};
        end else begin
            state_d.sh = {state_q.sh[SARC_W-2:0], chain_in};
        end
        // MSB shows before the first edge, no latency
        serial_bit = state_q.started ? state_q.sh[SARC_W-1]
                                     : hold_word[SARC_W-1];
    end

    // hold_word only changes while link_clear is high, so it is
    // stable whenever this clock runs
    always_ff @(posedge serial_clk or posedge link_clear) begin
        if (link_clear) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule

module sarc_adc_ctrl import sarc_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic convert_strobe,
    input wire logic chain_select,
    input wire logic read_enable_or_chain_in,
    input wire logic [SARC_W-1:0] sample_level,
    input wire logic serial_clk,
    output logic busy,
    output logic nap,
    output logic [SARC_W-1:0] sampling_cap_dac,
    output logic serial_out,
    output logic serial_out_oe
);
    typedef struct packed {
        logic cnv_prev;
        logic [SARC_W-1:0] held;
        logic [SARC_W-1:0] trial;
        logic [SARC_W-1:0] bit_ptr;
        logic [SARC_TMR_W-1:0] tmr;
        sarc_state_e state;
        logic busy;
        logic oe;
        logic [SARC_W-1:0] hold_word;
    } sarc_ctrl_s;

    sarc_ctrl_s state_q;
    sarc_ctrl_s state_d;
    logic cnv_rise;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [SARC_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [SARC_W-1:0] fifo_out_data;
    logic chain_in;
    logic cnv_sync;
    logic chain_sync;
    logic rdl_sync;
    logic [SARC_W-1:0] smp_sync;
    logic link_clear;

    sarc_sync u_cnv_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin(convert_strobe),
        .synced(cnv_sync)
    );

    sarc_sync u_chain_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin(chain_select),
        .synced(chain_sync)
    );

    sarc_sync u_rdl_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin(read_enable_or_chain_in),
        .synced(rdl_sync)
    );

    sarc_sync #(
        .WIDTH(SARC_W)
    ) u_smp_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin(sample_level),
        .synced(smp_sync)
    );

    sarc_fifo #(
        .WIDTH(SARC_W),
        .DEPTH(SARC_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // in normal mode nothing upstream: pad with zeros
    assign chain_in = chain_sync && read_enable_or_chain_in;

    // reset also clears the link side, so the output is defined
    // before the first conversion even though it has no reset pin
    assign link_clear = state_q.busy || !resetn;

    sarc_shift u_shift (
        .serial_clk(serial_clk),
        .link_clear(link_clear),
        .hold_word(state_q.hold_word),
        .chain_in(chain_in),
        .serial_bit(serial_out)
    );

    always_comb begin
        state_d = state_q;
        state_d.cnv_prev = cnv_sync;

        // chain mode always drives; normal mode follows enable
        state_d.oe = chain_sync || !rdl_sync;

        // edge found on the synced strobe, never on the raw pin
        cnv_rise = cnv_sync && !state_q.cnv_prev;
        fifo_in_valid = 1'b0;
        fifo_in_data = state_q.trial ^ SARC_SIGN_BIT;
        fifo_out_ready = 1'b0;

        unique case (state_q.state)
            ST_NAP: begin
                state_d.held = smp_sync;
                // edges during a conversion are not seen: host spacing
                if (cnv_rise) begin
                    state_d.state = ST_CONV;
                    state_d.busy = 1'b1;
                    state_d.tmr = SARC_TMR_RST;
                    state_d.bit_ptr = SARC_SIGN_BIT;
                    state_d.trial = SARC_SIGN_BIT;
                end
            end
            ST_CONV: begin
                if (state_q.bit_ptr != '0) begin
                    // drop the trial bit if the dac overshoots
                    if (state_q.trial > state_q.held) begin
                        state_d.trial = state_q.trial & ~state_q.bit_ptr;
                    end
                    state_d.trial =
                        state_d.trial | (state_q.bit_ptr >> 1);
                    state_d.bit_ptr = state_q.bit_ptr >> 1;
                end
                if (state_q.tmr != SARC_CONV_LAST) begin
                    state_d.tmr = state_q.tmr + 1'b1;
                end else begin
                    // a full buffer stretches the conversion
                    fifo_in_valid = 1'b1;
                    if (fifo_in_ready) begin
                        state_d.state = ST_XFER;
                    end
                end
            end
            ST_XFER: begin
                fifo_out_ready = 1'b1;
                if (fifo_out_valid) begin
                    state_d.hold_word = fifo_out_data;
                    state_d.busy = 1'b0;
                    state_d.state = ST_NAP;
                end
            end

            // the fourth code of the state field is unused
            default: begin
                state_d.state = ST_NAP;
                state_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign busy = state_q.busy;
    assign nap = state_q.state == ST_NAP;
    assign sampling_cap_dac = state_q.trial;
    assign serial_out_oe = state_q.oe;
endmodule

// File: verification/sarc_adc_ctrl_properties.sv
`timescale 1ns/100ps
module sarc_chk import sarc_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic convert_strobe,
    input wire logic chain_select,
    input wire logic read_enable_or_chain_in,
    input wire logic [SARC_W-1:0] sample_level,
    input wire logic serial_clk,
    input wire logic busy,
    input wire logic nap,
    input wire logic [SARC_W-1:0] sampling_cap_dac,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // timer cycles, the last of which pushes, plus one hand-off cycle
    localparam int BUSY_HI = SARC_CONV_CYC + 1;
    int busy_cnt_q;
    int up_q;
    // enable path is only judged once its sync pipe holds real pin values
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_q <= 0;
            up_q <= 0;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
            up_q <= (up_q < 4) ? up_q + 1 : up_q;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_busy_rise: assert property ($rose(convert_strobe) && nap |-> ##[2:3] busy)
        else $error("busy did not follow the strobe");
    a_busy_len: assert property ($fell(busy) |-> busy_cnt_q == BUSY_HI)
        else $error("busy length wrong");
    a_nap_busy: assert property (busy |-> !nap)
        else $error("nap while busy");
    a_nap_after: assert property ($fell(busy) |-> nap)
        else $error("no nap after conversion");
    a_start_cause: assert property ($rose(busy) |-> $past(convert_strobe, 2) && $past(nap))
        else $error("conversion without strobe");
    a_sar_first: assert property ($rose(busy) |-> sampling_cap_dac == SARC_SIGN_BIT)
        else $error("first trial not half scale");
    a_msb_ready: assert property ($fell(busy) |-> serial_out == ~sample_level[SARC_W-1])
        else $error("sign bit not ready at busy fall");
    a_oe_follow: assert property (up_q == 4 |-> serial_out_oe == ($past(chain_select, 3) | ~$past(read_enable_or_chain_in, 3)))
        else $error("output enable wrong");
    c_conv: cover property ($fell(busy));
    c_chain: cover property (chain_select && $fell(busy));
    c_oe_off: cover property ($fell(serial_out_oe));
endmodule

// File: verification/sarc_host_model.sv
`timescale 1ns/100ps
module sarc_host (
    input wire logic sys_clk,
    input wire logic busy,
    input wire logic sdo_wire,
    output logic convert_strobe,
    output logic serial_clk,
    output logic line_out
);
    initial begin
        convert_strobe = 1'b0;
        serial_clk = 1'b0;
        line_out = 1'b1;
    end
    task automatic set_line(input logic v);
        @(posedge sys_clk);
        #1 line_out = v;
    endtask
    task automatic convert(input logic chain, input logic [15:0] up,
                           input int n, output logic [31:0] word);
        int k;
        word = '0;
        #2000;
        @(posedge sys_clk);
        #1 convert_strobe = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 convert_strobe = 1'b0;
        k = 0;
        // clock stays still until busy drops
        while (busy !== 1'b0 && k < 60) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        for (k = 0; k < n; k++) begin
            word = {word[30:0], sdo_wire};
            if (chain && k < 16)
                line_out = up[15-k];
            #62.5 serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
        end
        // hold time over: do not leave the last bit standing
        if (chain)
            line_out = ~line_out;
    endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    import sarc_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic chain_select = 1'b0;
    logic [SARC_W-1:0] sample_level = 16'h0000;
    logic convert_strobe, serial_clk, line, busy, nap, serial_out;
    logic serial_out_oe;
    logic [SARC_W-1:0] sampling_cap_dac;
    int fails = 0;
    int samples_checked = 0;
    always #20 sys_clk = ~sys_clk;
    sarc_adc_ctrl i_dut (.sys_clk(sys_clk), .resetn(resetn),
        .convert_strobe(convert_strobe), .chain_select(chain_select),
        .read_enable_or_chain_in(line), .sample_level(sample_level),
        .serial_clk(serial_clk), .busy(busy), .nap(nap),
        .sampling_cap_dac(sampling_cap_dac), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe));
    sarc_host i_host (.sys_clk(sys_clk), .busy(busy),
        .sdo_wire(serial_out_oe ? serial_out : 1'bz),
        .convert_strobe(convert_strobe), .serial_clk(serial_clk),
        .line_out(line));
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_oe;
        i_host.set_line(1'b1);
        repeat (4) @(posedge sys_clk);
        #5 check("oe released", 32'h0, {31'h0, serial_out_oe});
        i_host.set_line(1'b0);
        repeat (4) @(posedge sys_clk);
        #5 check("oe driven", 32'h1, {31'h0, serial_out_oe});
    endtask
    // 20 clocks: the 4 beyond the word must read zero
    task automatic t_normal(input logic [15:0] lvl);
        logic [31:0] w;
        @(posedge sys_clk);
        #1 sample_level = lvl;
        i_host.convert(1'b0, 16'h0000, 20, w);
        check("word", {12'h000, lvl ^ SARC_SIGN_BIT, 4'h0}, w);
        check("nap", 32'h1, {31'h0, nap});
    endtask
    task automatic t_chain(input logic [15:0] lvl, input logic [15:0] up);
        logic [31:0] w;
        @(posedge sys_clk);
        #1 chain_select = 1'b1;
        sample_level = lvl;
        i_host.convert(1'b1, up, 32, w);
        check("chain word", {lvl ^ SARC_SIGN_BIT, up}, w);
        i_host.set_line(1'b0);
        chain_select = 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 resetn = 1'b1;
        t_oe();
        t_normal(16'h0000);
        t_normal(16'hFFFF);
        t_normal(16'h8000);
        t_chain(16'h5A0F, 16'hA5C3);
        t_normal(16'h1234);
        give_verdict();
    end
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule
bind sarc_adc_ctrl sarc_chk i_chk (.sys_clk(sys_clk), .resetn(resetn),
    .convert_strobe(convert_strobe), .chain_select(chain_select),
    .read_enable_or_chain_in(read_enable_or_chain_in),
    .sample_level(sample_level), .serial_clk(serial_clk), .busy(busy),
    .nap(nap), .sampling_cap_dac(sampling_cap_dac),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
